// *** core/flash_host_ctrl.sv ***
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
module flash_host_ctrl
    import flash_host_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    // command port
    input  wire logic [7:0]                 reg_addr_in,
    input  wire logic [31:0]                reg_wdata_in,
    input  wire logic                       reg_write_in,
    input  wire logic                       reg_read_in,
    output logic      [31:0]                reg_rdata_out,
    // flash pins
    output flash_host_pkg::flash_pins_t     pins_out,
    output logic      [15:0]                dq_out,
    output logic      [15:0]                dq_oe_out,
    input  wire logic [15:0]                dq_in,
    input  wire logic                       done_flag_in
);
    import flash_host_pkg::*;

    host_state_t state, next_state;
    logic [12:0] cnt, next_cnt;
    logic [20:0] addr_reg, next_addr_reg;
    logic [15:0] wdata, next_wdata;
    logic [15:0] rdata, next_rdata;
    logic [1:0]  cfg, next_cfg;
    logic        aborted, next_aborted;
    logic        refused, next_refused;
    logic        timeout, next_timeout;
    flash_pins_t next_pins;
    logic [15:0] next_dq, next_dq_oe;
    logic [31:0] next_rd;
    logic        cmd_wr;
    logic        byte_mode;

    // decode of a register offset, used by both strobes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign cmd_wr    = reg_write_in && hit(reg_addr_in, CMD_OFS);
    assign byte_mode = cfg[CFG_BYTE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: one pin cycle per command, pins idle in standby between them
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_rdata   = rdata;
        next_aborted = aborted;
        next_refused = refused;
        next_timeout = timeout;
        next_pins    = pins_out;
        next_dq      = dq_out;
        next_dq_oe   = dq_oe_out;
        // status clears are write-one; set below wins over them
        if (reg_write_in && hit(reg_addr_in, STATUS_OFS)) begin
            next_aborted = aborted && !reg_wdata_in[ST_ABORT_BIT];
            next_refused = refused && !reg_wdata_in[ST_REFUSED_BIT];
            next_timeout = timeout && !reg_wdata_in[ST_TIMEOUT_BIT];
        end
        if (cmd_wr && state != ST_IDLE) begin
            next_refused = 1'b1;
        end
        unique case (state)
            ST_IDLE: begin
                next_pins.chip_select_n   = 1'b1;
                next_pins.output_enable_n = 1'b1;
                next_pins.write_strobe_n  = 1'b1;
                next_pins.hw_clear_n      = 1'b1;
                next_pins.width_select_n  = !byte_mode;
                next_pins.protect_accel_pin = 1'b0;
                next_dq_oe = 16'h0000;
                next_cnt   = 13'h0000;
                if (cmd_wr) begin
                    next_pins.addr = addr_reg[20:1];
                    // narrow mode drives top line as address lsb
                    next_dq    = {addr_reg[0], 7'h00, wdata[7:0]};
                    if (byte_mode) begin
                        next_dq = {addr_reg[0], 7'h00, wdata[7:0]};
                    end else begin
                        next_dq = wdata;
                    end
                    next_dq_oe = byte_mode ? 16'h8000 : 16'h0000;
                    unique case (reg_wdata_in[1:0])
                        OP_READ: begin
                            next_pins.chip_select_n   = 1'b0;
                            next_pins.output_enable_n = 1'b0;
                            next_state = ST_READ;
                        end
                        OP_WRITE: begin
                            // write levels, output enable stays high
                            next_pins.chip_select_n  = 1'b0;
                            next_pins.write_strobe_n = 1'b0;
                            // accel level only in program writes
                            next_pins.protect_accel_pin = cfg[CFG_ACCEL_BIT];
                            next_dq_oe = byte_mode ? 16'h80FF : 16'hFFFF;
                            next_state = ST_WRITE;
                        end
                        OP_CLEAR: begin
                            // flag an operation the clear pulse will abort
                            if (!done_flag_in) begin
                                next_aborted = 1'b1;
                            end
                            next_pins.hw_clear_n = 1'b0;
                            next_dq_oe = 16'h0000;
                            next_state = ST_CLEAR_LOW;
                        end
                        default: begin
                            next_dq_oe = 16'h0000;
                        end
                    endcase
                end
            end
            ST_READ: begin
                next_cnt = cnt + 13'h0001;
                // data taken only after full select access time
                if (cnt + 13'h0001 >= CE_CYC) begin
                    // narrow reads keep only the low byte
                    next_rdata = byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
                    next_pins.chip_select_n   = 1'b1;
                    next_pins.output_enable_n = 1'b1;
                    next_dq_oe = 16'h0000;
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // each command cycle is one write; short mode needs two
                next_cnt = cnt + 13'h0001;
                if (cnt + 13'h0001 >= WP_CYC) begin
                    next_pins.write_strobe_n = 1'b1;
                    next_cnt   = 13'h0000;
                    next_state = ST_WRITE_REC;
                end
            end
            ST_WRITE_REC: begin
                // data and select held past the rising strobe edge
                next_cnt = cnt + 13'h0001;
                if (cnt + 13'h0001 >= WPH_CYC) begin
                    next_pins.chip_select_n     = 1'b1;
                    next_pins.protect_accel_pin = 1'b0;
                    next_dq_oe = 16'h0000;
                    next_state = ST_IDLE;
                end
            end
            ST_CLEAR_LOW: begin
                // hold the clear pulse for its least width
                next_cnt = cnt + 13'h0001;
                if (cnt + 13'h0001 >= RP_CYC) begin
                    next_pins.hw_clear_n = 1'b1;
                    next_cnt   = 13'h0000;
                    next_state = ST_CLEAR_WAIT;
                end
            end
            ST_CLEAR_WAIT: begin
                // wait for the busy flag, bounded by the ready interval
                next_cnt = cnt + 13'h0001;
                if (done_flag_in || cnt + 13'h0001 >= READY_CYC) begin
                    next_timeout = next_timeout || !done_flag_in;
                    next_cnt   = 13'h0000;
                    next_state = ST_CLEAR_REC;
                end
            end
            ST_CLEAR_REC: begin
                // recovery before any read is allowed
                next_cnt = cnt + 13'h0001;
                if (cnt + 13'h0001 >= RH_CYC) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state     <= ST_IDLE;
            cnt       <= 13'h0000;
            rdata     <= DATA_RST;
            aborted   <= 1'b0;
            refused   <= 1'b0;
            timeout   <= 1'b0;
            pins_out  <= '{addr: 20'h0_0000, chip_select_n: 1'b1, output_enable_n: 1'b1,
                           write_strobe_n: 1'b1, hw_clear_n: 1'b1, width_select_n: 1'b1,
                           protect_accel_pin: 1'b0};
            dq_out    <= 16'h0000;
            dq_oe_out <= 16'h0000;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            rdata     <= next_rdata;
            aborted   <= next_aborted;
            refused   <= next_refused;
            timeout   <= next_timeout;
            pins_out  <= next_pins;
            dq_out    <= next_dq;
            dq_oe_out <= next_dq_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command port registers; writes land at once, read data one cycle later
    always_comb begin
        next_addr_reg = addr_reg;
        next_wdata    = wdata;
        next_cfg      = cfg;
        next_rd       = 32'h0000_0000;
        // settings change only between cycles so pins never glitch mid-cycle
        if (reg_write_in && state == ST_IDLE) begin
            if (hit(reg_addr_in, ADDR_OFS)) begin
                next_addr_reg = reg_wdata_in[20:0];
            end
            if (hit(reg_addr_in, DATA_OFS)) begin
                next_wdata = reg_wdata_in[15:0];
            end
            if (hit(reg_addr_in, CFG_OFS)) begin
                next_cfg = reg_wdata_in[1:0];
            end
        end
        if (reg_read_in) begin
            if (hit(reg_addr_in, ADDR_OFS)) begin
                next_rd = {11'h000, addr_reg};
            end else if (hit(reg_addr_in, DATA_OFS)) begin
                next_rd = {16'h0000, rdata};
            end else if (hit(reg_addr_in, CFG_OFS)) begin
                next_rd = {30'h0000_0000, cfg};
            end else if (hit(reg_addr_in, STATUS_OFS)) begin
                next_rd = {27'h000_0000, timeout, refused, aborted, done_flag_in,
                           state != ST_IDLE};
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_reg      <= ADDR_RST;
            wdata         <= DATA_RST;
            cfg           <= CFG_RST;
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            addr_reg      <= next_addr_reg;
            wdata         <= next_wdata;
            cfg           <= next_cfg;
            reg_rdata_out <= next_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // helper counters seen only by the checks below
    logic [12:0] ce_low_cnt;
    logic [12:0] clr_low_cnt;
    logic [12:0] since_clr;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ce_low_cnt  <= 13'h0000;
            clr_low_cnt <= 13'h0000;
            since_clr   <= 13'h1FFF;
        end else begin
            ce_low_cnt  <= pins_out.chip_select_n ? 13'h0000 : ce_low_cnt + 13'h0001;
            clr_low_cnt <= pins_out.hw_clear_n ? 13'h0000 : clr_low_cnt + 13'h0001;
            if (!pins_out.hw_clear_n) begin
                since_clr <= 13'h0000;
            end else if (since_clr != 13'h1FFF) begin
                since_clr <= since_clr + 13'h0001;
            end
        end
    end

    a_write_levels: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !pins_out.write_strobe_n |-> !pins_out.chip_select_n && pins_out.output_enable_n)
        else $error("write strobe low without select or with output enable");
    a_read_levels: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !pins_out.output_enable_n |-> !pins_out.chip_select_n && pins_out.write_strobe_n)
        else $error("output enable low outside a proper read");
    a_read_access: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(pins_out.output_enable_n) && $past(state) == ST_READ |->
            $past(ce_low_cnt) + 13'h0001 >= CE_CYC)
        else $error("read data taken before select access time");
    a_accel_write_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pins_out.protect_accel_pin |-> !pins_out.chip_select_n && pins_out.output_enable_n
            && pins_out.hw_clear_n)
        else $error("accelerate level outside a program write");
    a_clear_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(pins_out.hw_clear_n) |-> $past(clr_low_cnt) + 13'h0001 >= RP_CYC)
        else $error("clear pulse shorter than its least width");
    a_clear_recovery: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(pins_out.output_enable_n) |-> since_clr >= RH_CYC)
        else $error("read started inside clear recovery");
    a_narrow_lines: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !pins_out.width_select_n |-> dq_oe_out[14:8] == 7'h00)
        else $error("middle data lines driven in narrow mode");
    a_idle_standby: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state == ST_IDLE && $past(state) == ST_IDLE |=>
            pins_out.chip_select_n && pins_out.hw_clear_n || state != ST_IDLE)
        else $error("pins not in standby while idle");
    a_ready_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state == ST_CLEAR_WAIT |-> cnt < READY_CYC)
        else $error("waited past the ready interval");

endmodule

// *** include/flash_host_pkg.sv ***
package flash_host_pkg;

    // clock and pin timing, figures in ns
    localparam int CLK_NS             = 5;
    localparam int T_CE_NS            = 100;
    localparam int T_WP_NS            = 50;
    localparam int T_WPH_NS           = 30;
    localparam int MIN_CLEAR_PULSE_NS = 500;
    localparam int CLEAR_RECOVERY_NS  = 50;
    localparam int T_READY_NS         = 20000;

    // least times round up to whole cycles
    localparam logic [12:0] CE_CYC    = 13'((T_CE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] WP_CYC    = 13'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] WPH_CYC   = 13'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] RP_CYC    = 13'((MIN_CLEAR_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] RH_CYC    = 13'((CLEAR_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] READY_CYC = 13'((T_READY_NS + CLK_NS - 1) / CLK_NS);

    // register byte offsets of the command port
    localparam logic [7:0] CMD_OFS    = 8'h00;
    localparam logic [7:0] ADDR_OFS   = 8'h04;
    localparam logic [7:0] DATA_OFS   = 8'h08;
    localparam logic [7:0] CFG_OFS    = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // command codes written to the command register
    localparam logic [1:0] OP_READ  = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_CLEAR = 2'h3;

    // field positions
    localparam int CFG_BYTE_BIT    = 0;
    localparam int CFG_ACCEL_BIT   = 1;
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_READY_BIT    = 1;
    localparam int ST_ABORT_BIT    = 2;
    localparam int ST_REFUSED_BIT  = 3;
    localparam int ST_TIMEOUT_BIT  = 4;

    // reset values
    localparam logic [20:0] ADDR_RST = 21'h00_0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [1:0]  CFG_RST  = 2'h0;

    // control pins toward the flash
    typedef struct packed {
        logic [19:0] addr;
        logic        chip_select_n;
        logic        output_enable_n;
        logic        write_strobe_n;
        logic        hw_clear_n;
        logic        width_select_n;
        logic        protect_accel_pin;
    } flash_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_WRITE, ST_WRITE_REC, ST_CLEAR_LOW, ST_CLEAR_WAIT, ST_CLEAR_REC
    } host_state_t;

endpackage

// *** tb/flash_dev_model.sv ***
`timescale 1ns/1ps
module flash_dev_model (
    // behavioural timing base
    input  wire logic                        clk_in,
    // controller side of the pins
    input  wire flash_host_pkg::flash_pins_t pins_in,
    input  wire logic [15:0]                 dq_drv_in,
    input  wire logic [15:0]                 dq_oe_in,
    // device outputs
    output logic      [15:0]                 dq_bus_out,
    output logic                             done_flag_out,
    output logic      [7:0]                  viol_out,
    output logic      [7:0]                  accel_progs_out
);
    import flash_host_pkg::*;
    parameter int PROG_CYC     = 80;
    parameter int CLR_BUSY_CYC = 150;
    logic [15:0] mem [int];
    logic [15:0] last_bus = 16'h0000;
    logic [15:0] w;
    logic [15:0] pw;
    logic [15:0] dev_en;
    logic [19:0] prog_addr = 20'h0_0000;
    logic        drive;
    logic        prev_we = 1'b1;
    int          busy_cnt = 0;
    int          clr_cnt = 0;
    int          rh_cnt = 1000;
    int          rd_cnt = 0;
    int          wp_cnt = 0;
    initial viol_out = 8'h00;
    initial accel_progs_out = 8'h00;
    function automatic logic [15:0] word_at(input logic [19:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
    endfunction
    // busy runs on whatever the select does
    assign done_flag_out = (busy_cnt == 0);
    // data follow the address, but a still address alone does not keep them driven
    // drive only while selected for a read; else floating lines wander
    always @* begin
        drive = !pins_in.chip_select_n && !pins_in.output_enable_n &&
                pins_in.write_strobe_n && pins_in.hw_clear_n;
        w = word_at(pins_in.addr);
        // only the bank under program or erase returns garbage
        if (busy_cnt != 0 && (pins_in.addr[19:18] == 2'b11) == (prog_addr[19:18] == 2'b11))
            w = ~w;
        // nothing valid before the full select access time
        if (rd_cnt < int'(CE_CYC))
            w = ~last_bus;
        // byte mode: low byte only, top line carries the address lsb
        if (!pins_in.width_select_n)
            w = {8'h00, dq_drv_in[15] ? w[15:8] : w[7:0]};
        dev_en = drive ? (pins_in.width_select_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
        for (int i = 0; i < 16; i++) begin
            dq_bus_out[i] = dq_oe_in[i] ? dq_drv_in[i] : (dev_en[i] ? w[i] : ~last_bus[i]);
        end
    end
    // device state moves on the falling edge, clear of the controller's sampling
    always @(negedge clk_in) begin
        last_bus = dq_bus_out;
        if (busy_cnt != 0) busy_cnt--;
        // high level only inside a write cycle
        if (pins_in.protect_accel_pin && (pins_in.chip_select_n || !pins_in.output_enable_n))
            viol_out++;
        if (!pins_in.hw_clear_n) begin
            // abort; busy through internal reset only if it was busy
            if (clr_cnt == 0 && busy_cnt != 0) busy_cnt = CLR_BUSY_CYC;
            clr_cnt++;
            rh_cnt = 0;
            rd_cnt = 0;
            wp_cnt = 0;
        end else begin
            if (clr_cnt != 0 && clr_cnt < int'(RP_CYC) - 1) viol_out++;
            clr_cnt = 0;
            if (rh_cnt < 1000) rh_cnt++;
            // no read inside the recovery time
            if (drive && rd_cnt == 0 && rh_cnt < int'(RH_CYC) - 1) viol_out++;
            rd_cnt = drive ? rd_cnt + 1 : 0;
            if (!pins_in.chip_select_n && !pins_in.write_strobe_n) begin
                if (!pins_in.output_enable_n) viol_out++;
                wp_cnt++;
            end else begin
                // take the unit on the strobe's rise; accel is faster
                if (!prev_we && !pins_in.chip_select_n && wp_cnt >= int'(WP_CYC) - 1) begin
                    pw = word_at(pins_in.addr);
                    if (pins_in.width_select_n) pw = dq_bus_out;
                    else if (dq_bus_out[15]) pw[15:8] = dq_bus_out[7:0];
                    else pw[7:0] = dq_bus_out[7:0];
                    mem[int'(pins_in.addr)] = pw;
                    prog_addr = pins_in.addr;
                    busy_cnt = pins_in.protect_accel_pin ? PROG_CYC / 4 : PROG_CYC;
                    if (pins_in.protect_accel_pin) accel_progs_out++;
                end
                wp_cnt = 0;
            end
        end
        prev_we = pins_in.write_strobe_n;
    end
endmodule

// *** tb/test_flash_host_ctrl.sv ***
`timescale 1ns/1ps
module test_flash_host_ctrl;
    import flash_host_pkg::*;
    logic        clk_in;
    logic        rst_n_in;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in;
    logic        reg_write_in;
    logic        reg_read_in;
    logic [31:0] reg_rdata_out;
    flash_pins_t pins;
    logic [15:0] dq_out;
    logic [15:0] dq_oe_out;
    logic [15:0] dq_bus;
    logic        done_flag;
    logic [7:0]  viol;
    logic [7:0]  accel_progs;
    logic [31:0] rd;
    int          fails = 0;
    int          checks_done = 0;
    int          cycles = 0;
    flash_host_ctrl u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .pins_out(pins), .dq_out(dq_out),
        .dq_oe_out(dq_oe_out), .dq_in(dq_bus), .done_flag_in(done_flag));
    flash_dev_model u_flash (.clk_in(clk_in), .pins_in(pins), .dq_drv_in(dq_out),
        .dq_oe_in(dq_oe_out), .dq_bus_out(dq_bus), .done_flag_out(done_flag),
        .viol_out(viol), .accel_progs_out(accel_progs));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        @(posedge clk_in);
        d = reg_rdata_out;
    endtask
    // bounded poll of one status bit
    task automatic wait_bit(input int b, input logic v);
        logic [31:0] s;
        int          n;
        n = 0;
        s = {32{~v}};
        while (s[b] !== v && n < 2000) begin
            reg_rd(STATUS_OFS, s);
            n++;
        end
        chk("status poll", 32'(s[b]), 32'(v));
    endtask
    task automatic fl_write(input logic [20:0] a, input logic [15:0] d);
        reg_wr(ADDR_OFS, {11'h000, a});
        reg_wr(DATA_OFS, {16'h0000, d});
        reg_wr(CMD_OFS, {30'h0000_0000, OP_WRITE});
        wait_bit(ST_BUSY_BIT, 1'b0);
    endtask
    task automatic fl_read(input logic [20:0] a, output logic [31:0] d);
        reg_wr(ADDR_OFS, {11'h000, a});
        reg_wr(CMD_OFS, {30'h0000_0000, OP_READ});
        wait_bit(ST_BUSY_BIT, 1'b0);
        reg_rd(DATA_OFS, d);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("idle pins", 32'(pins), 32'h0000_003E);
        chk("dq enable", {16'h0000, dq_oe_out}, 32'h0000_0000);
        chk("rdata", reg_rdata_out, 32'h0000_0000);
        reg_rd(CFG_OFS, rd);
        chk("cfg", rd, 32'h0000_0000);
    endtask
    // second bank programs while the first one is read back
    task automatic t_word();
        fl_write(21'h1F_0002, 16'h3CC3);
        wait_bit(ST_READY_BIT, 1'b1);
        fl_write(21'h00_2468, 16'hA55A);
        fl_read(21'h1F_0002, rd);
        chk("bank one", rd, 32'h0000_3CC3);
        chk("standby", {26'h000_0000, pins[5:0]}, 32'h0000_003E);
        wait_bit(ST_READY_BIT, 1'b1);
        fl_read(21'h00_2468, rd);
        chk("bank two", rd, 32'h0000_A55A);
    endtask
    task automatic t_byte();
        reg_wr(CFG_OFS, 32'h0000_0001);
        fl_write(21'h00_0201, 16'h005A);
        wait_bit(ST_READY_BIT, 1'b1);
        fl_write(21'h00_0200, 16'h0069);
        wait_bit(ST_READY_BIT, 1'b1);
        fl_read(21'h00_0201, rd);
        chk("byte high", rd, 32'h0000_005A);
        fl_read(21'h00_0200, rd);
        chk("byte low", rd, 32'h0000_0069);
        reg_wr(CFG_OFS, 32'h0000_0000);
        fl_read(21'h00_0200, rd);
        chk("byte pair", rd, 32'h0000_5A69);
    endtask
    task automatic t_accel();
        reg_wr(CFG_OFS, 32'h0000_0002);
        fl_write(21'h00_0400, 16'h1111);
        chk("accel used", 32'(accel_progs), 32'h0000_0001);
        chk("accel off", 32'(pins.protect_accel_pin), 32'h0000_0000);
        reg_wr(CFG_OFS, 32'h0000_0000);
        wait_bit(ST_READY_BIT, 1'b1);
        fl_read(21'h00_0400, rd);
        chk("accel data", rd, 32'h0000_1111);
    endtask
    // commands and setup while busy are turned away
    task automatic t_refuse();
        reg_wr(ADDR_OFS, 32'h0000_0600);
        reg_wr(DATA_OFS, 32'h0000_7E7E);
        reg_wr(CMD_OFS, {30'h0000_0000, OP_WRITE});
        reg_wr(CMD_OFS, {30'h0000_0000, OP_READ});
        reg_wr(ADDR_OFS, 32'h0000_0002);
        wait_bit(ST_BUSY_BIT, 1'b0);
        reg_rd(ADDR_OFS, rd);
        chk("addr kept", rd, 32'h0000_0600);
        reg_rd(STATUS_OFS, rd);
        chk("refused", 32'(rd[ST_REFUSED_BIT]), 32'h0000_0001);
        reg_wr(STATUS_OFS, 32'h0000_0008);
        reg_rd(STATUS_OFS, rd);
        chk("refused clr", 32'(rd[ST_REFUSED_BIT]), 32'h0000_0000);
        reg_rd(8'h14, rd);
        chk("unmapped", rd, 32'h0000_0000);
    endtask
    task automatic t_clear();
        fl_write(21'h00_2468, 16'hC0DE);
        reg_wr(CMD_OFS, {30'h0000_0000, OP_CLEAR});
        wait_bit(ST_BUSY_BIT, 1'b0);
        reg_rd(STATUS_OFS, rd);
        chk("abort flag", {27'h000_0000, rd[4:0]}, 32'h0000_0006);
        reg_wr(STATUS_OFS, 32'h0000_001C);
        reg_wr(CMD_OFS, {30'h0000_0000, OP_CLEAR});
        wait_bit(ST_BUSY_BIT, 1'b0);
        reg_rd(STATUS_OFS, rd);
        chk("idle clear", {27'h000_0000, rd[4:0]}, 32'h0000_0002);
        fl_read(21'h1F_0002, rd);
        chk("array read", rd, 32'h0000_3CC3);
        chk("pin rules", 32'(viol), 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, well above the thousand or so cycles the run needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        rst_n_in     = 1'b0;
        reg_addr_in  = 8'h00;
        reg_wdata_in = 32'h0000_0000;
        reg_write_in = 1'b0;
        reg_read_in  = 1'b0;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_word();
        t_byte();
        t_accel();
        t_refuse();
        t_clear();
        end_sim();
    end
endmodule
